//--- spsl_pkg.sv
// Purpose: Shared constants and carriers for the SPI slave port
// Assumes: Serial clock sampled by the 100 MHz system clock
// Notes: Select mode encodings and flag layout
package spsl_pkg;
   localparam int DATA_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [1:0] MODE_3WIRE = 2'h0;
   localparam logic [1:0] MODE_4WIRE = 2'h1;
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int NSS_LEAD_CLKS = 2;

   typedef struct packed {
      logic port_enable_bit;
      logic master_select_bit;
      logic select_mode_hi;
      logic select_mode_lo;
      logic clk_pol;
      logic clk_pha;
      logic irq_enable;
   } spsl_ctrl_s;

   typedef struct packed {
      logic xfer_done_flag;
      logic write_collision_flag;
      logic rx_overrun_flag;
   } spsl_flags_s;
endpackage : spsl_pkg

//--- spsl_port.sv
// Purpose: SPI slave serial port with double-buffered transmit
// Assumes: Serial lines are asynchronous to clk and pass two flip-flops
// Notes: Control bits are plain ports; flags clear by one-cycle pulses
// Function
// [RL1] Enabled and not master-selected means the port works as a slave
// [RL2] Master drives serial clock; bits shift in on mosi, out on miso
// [RL3] Bit counter counts edges; after 8 bits set done flag, copy byte
// [RL4] Reading the data register returns the receive buffer
// [RL5] Slave never starts a transfer; only master clock edges move bits
// [RL6] Data register writes go into a separate transmit holding buffer
// [RL7] Empty shift register takes the transmit buffer at once
// [RL8] Busy shift register loads from buffer after the final clock edge
// [RL9] Mode hi 0, lo 1 selects 4-wire; this is the reset default
// [RL10] In 4-wire the select input enables the port while low
// [RL11] In 4-wire a select falling edge clears the bit counter
// [RL12] Master lowers select at least 2 clocks before first clock edge
// [RL13] Both mode bits 0 selects 3-wire; select input ignored
// [RL14] In 3-wire only toggling the enable bit clears the bit counter
// [RL15] Write while buffer still full is ignored and sets collision flag
// [RL16] Completion with unread receive byte keeps old byte, sets overrun
// [RL17] Flags raise interrupt when enabled and stay set until cleared
// [RL18] Sampling and shifting edges follow polarity and phase settings
`timescale 1ns/10ps
module spsl_port (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input spsl_pkg::spsl_ctrl_s ctrl,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic clr_done,
   input wire logic clr_collision,
   input wire logic clr_overrun,
   output logic [7:0] serial_data_reg,
   output spsl_pkg::spsl_flags_s flags,
   output logic irq,
   output logic slave_active,
   input wire logic sck,
   input wire logic mosi,
   input wire logic nss_n,
   output logic miso,
   output logic miso_oe_n
);
   logic [2:0] sck_sync_ff, nxt_sck_sync;
   logic [1:0] mosi_sync_ff, nxt_mosi_sync;
   logic [2:0] nss_sync_ff, nxt_nss_sync;
   logic [7:0] shift_ff, nxt_shift;
   logic [7:0] txbuf_ff, nxt_txbuf;
   logic txfull_ff, nxt_txfull;
   logic shfull_ff, nxt_shfull;
   logic [7:0] rxbuf_ff, nxt_rxbuf;
   logic rxfull_ff, nxt_rxfull;
   logic [2:0] bitcnt_ff, nxt_bitcnt;
   logic miso_ff, nxt_miso;
   logic sampled_ff, nxt_sampled;
   spsl_pkg::spsl_flags_s flags_ff, nxt_flags;
   logic [7:0] rdata_ff, nxt_rdata;
   logic mode4, mode3, selected, slave_en;
   logic sck_rise, sck_fall, lead_edge, trail_edge;
   logic nss_lvl, nss_fall, mosi_lvl;
   logic sample_edge, shift_edge, done_evt, wr_ok;

   // Synchronised pin levels and edges
   assign sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
   assign sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
   assign nss_lvl = nss_sync_ff[1];
   assign nss_fall = ~nss_sync_ff[1] & nss_sync_ff[2];
   assign mosi_lvl = mosi_sync_ff[1];
   // [RL18] Edge choice by polarity
   assign lead_edge = ctrl.clk_pol ? sck_fall : sck_rise;
   assign trail_edge = ctrl.clk_pol ? sck_rise : sck_fall;

   // [RL9] Mode decode
   assign mode4 = ({ctrl.select_mode_hi, ctrl.select_mode_lo} == spsl_pkg::MODE_4WIRE);
   // [RL13] Select ignored in 3-wire
   assign mode3 = ({ctrl.select_mode_hi, ctrl.select_mode_lo} == spsl_pkg::MODE_3WIRE);
   // [RL1] Slave operation
   assign slave_en = ctrl.port_enable_bit & ~ctrl.master_select_bit & (mode4 | mode3);
   // [RL10] Active low select
   assign selected = slave_en & (mode3 | ~nss_lvl);
   // [RL5] Only master clock edges move bits
   // [RL18] Phase picks sample edge
   assign sample_edge = selected & (ctrl.clk_pha ? trail_edge : lead_edge);
   assign shift_edge = selected & (ctrl.clk_pha ? lead_edge : trail_edge);
   // [RL3] Eighth sample ends the byte
   assign done_evt = sample_edge & (bitcnt_ff == spsl_pkg::BIT_LAST);
   // [RL15] Buffer must be empty to accept
   assign wr_ok = wr_strobe & ~txfull_ff;

   always_comb begin
      nxt_sck_sync = {sck_sync_ff[1:0], sck};
      nxt_mosi_sync = {mosi_sync_ff[0], mosi};
      nxt_nss_sync = {nss_sync_ff[1:0], nss_n};
      nxt_shift = shift_ff;
      nxt_txbuf = txbuf_ff;
      nxt_txfull = txfull_ff;
      nxt_shfull = shfull_ff;
      nxt_rxbuf = rxbuf_ff;
      nxt_rxfull = rxfull_ff;
      nxt_bitcnt = bitcnt_ff;
      nxt_miso = miso_ff;
      nxt_sampled = sampled_ff;
      nxt_flags = flags_ff;
      nxt_rdata = rdata_ff;
      // [RL17] Software clears
      if (clr_done) nxt_flags.xfer_done_flag = 1'b0;
      if (clr_collision) nxt_flags.write_collision_flag = 1'b0;
      if (clr_overrun) nxt_flags.rx_overrun_flag = 1'b0;
      // [RL4] Read returns receive buffer
      if (rd_strobe) begin
         nxt_rdata = rxbuf_ff;
         nxt_rxfull = 1'b0;
      end
      // [RL6] Write into holding buffer
      if (wr_ok) begin
         nxt_txbuf = wr_data;
         nxt_txfull = 1'b1;
      end
      // [RL15] Ignored write flags collision
      if (wr_strobe & txfull_ff) nxt_flags.write_collision_flag = 1'b1;
      // [RL14] Disabling clears counter
      if (!ctrl.port_enable_bit) begin
         nxt_bitcnt = spsl_pkg::BIT_ZERO;
         nxt_sampled = 1'b0;
      end else if (mode4 && nss_fall) begin
         // [RL11] Select fall clears counter
         nxt_bitcnt = spsl_pkg::BIT_ZERO;
         nxt_sampled = 1'b0;
         if (!ctrl.clk_pha) nxt_miso = shift_ff[7];
      end else begin
         // [RL2] Sample mosi on sample edge
         if (sample_edge) begin
            nxt_shift = {shift_ff[6:0], mosi_lvl};
            nxt_bitcnt = bitcnt_ff + 3'h1;
            nxt_sampled = 1'b1;
         end
         // [RL2] Drive next bit on shift edge
         if (shift_edge && (ctrl.clk_pha || sampled_ff)) nxt_miso = shift_ff[7];
         if (done_evt) begin
            // [RL3] Byte complete
            nxt_flags.xfer_done_flag = 1'b1;
            nxt_shfull = 1'b0;
            nxt_sampled = 1'b0;
            // [RL16] Overrun keeps old byte
            if (rxfull_ff && !rd_strobe) begin
               nxt_flags.rx_overrun_flag = 1'b1;
            end else begin
               nxt_rxbuf = {shift_ff[6:0], mosi_lvl};
               nxt_rxfull = 1'b1;
            end
         end
      end
      // [RL7] [RL8] Load shift register when idle or after last edge
      if (txfull_ff && (!shfull_ff || done_evt) && !(sample_edge && !done_evt)) begin
         nxt_shift = txbuf_ff;
         nxt_shfull = 1'b1;
         nxt_txfull = 1'b0;
         if (!ctrl.clk_pha) nxt_miso = txbuf_ff[7];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_sync_ff <= 3'h0;
         mosi_sync_ff <= 2'h0;
         nss_sync_ff <= 3'h7;
         shift_ff <= spsl_pkg::BYTE_ZERO;
         txbuf_ff <= spsl_pkg::BYTE_ZERO;
         txfull_ff <= 1'b0;
         shfull_ff <= 1'b0;
         rxbuf_ff <= spsl_pkg::BYTE_ZERO;
         rxfull_ff <= 1'b0;
         bitcnt_ff <= spsl_pkg::BIT_ZERO;
         miso_ff <= 1'b0;
         sampled_ff <= 1'b0;
         flags_ff <= '0;
         rdata_ff <= spsl_pkg::BYTE_ZERO;
      end else if (clk_en) begin
         sck_sync_ff <= nxt_sck_sync;
         mosi_sync_ff <= nxt_mosi_sync;
         nss_sync_ff <= nxt_nss_sync;
         shift_ff <= nxt_shift;
         txbuf_ff <= nxt_txbuf;
         txfull_ff <= nxt_txfull;
         shfull_ff <= nxt_shfull;
         rxbuf_ff <= nxt_rxbuf;
         rxfull_ff <= nxt_rxfull;
         bitcnt_ff <= nxt_bitcnt;
         miso_ff <= nxt_miso;
         sampled_ff <= nxt_sampled;
         flags_ff <= nxt_flags;
         rdata_ff <= nxt_rdata;
      end
   end

   assign serial_data_reg = rdata_ff;
   assign flags = flags_ff;
   // [RL17] Interrupt from sticky flags
   assign irq = ctrl.irq_enable & (flags_ff.xfer_done_flag | flags_ff.write_collision_flag
                                   | flags_ff.rx_overrun_flag);
   assign slave_active = selected;
   assign miso = miso_ff;
   // [RL10] Drive miso only while selected
   assign miso_oe_n = ~selected;

   // Assertions
   // [RL3] Done flag set
   a_done_sets_flag: assert property ( // [RL3]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && done_evt) |=> flags_ff.xfer_done_flag)
      else $error("done flag not set after byte");

   // [RL16] Overrun keeps byte
   a_overrun_keeps: assert property ( // [RL16]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && done_evt && rxfull_ff && !rd_strobe) |=> (rxbuf_ff == $past(rxbuf_ff)
      && flags_ff.rx_overrun_flag))
      else $error("overrun lost old byte");

   // [RL15] Collision write ignored
   a_collision_flag: assert property ( // [RL15]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && wr_strobe && txfull_ff) |=> (flags_ff.write_collision_flag
      && txbuf_ff == $past(txbuf_ff)))
      else $error("collision write not ignored");

   // [RL7] Idle shift loads
   a_empty_loads_now: assert property ( // [RL7]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && txfull_ff && !shfull_ff && !sample_edge) |=> (shfull_ff && !txfull_ff))
      else $error("idle shift register not loaded");

   // [RL8] Busy shift waits
   a_busy_waits: assert property ( // [RL8]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && shfull_ff && !done_evt && !wr_ok) |=> (txfull_ff == $past(txfull_ff)))
      else $error("busy shift register loaded early");

   // [RL8] Load after last edge
   a_done_loads_tx: assert property ( // [RL8]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && done_evt && txfull_ff) |=> (shift_ff == $past(txbuf_ff) && !txfull_ff))
      else $error("pending byte not loaded after last edge");

   // [RL11] Select fall clears
   a_nss_clears_cnt: assert property ( // [RL11]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && ctrl.port_enable_bit && mode4 && nss_fall) |=> bitcnt_ff == 3'h0)
      else $error("select fall did not clear counter");

   // [RL14] Disable clears counter
   a_disable_clears: assert property ( // [RL14]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && !ctrl.port_enable_bit) |=> bitcnt_ff == 3'h0)
      else $error("disable did not clear counter");

   // [RL5] No self start
   a_no_self_start: assert property ( // [RL5]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && !sample_edge && ctrl.port_enable_bit && !(mode4 && nss_fall))
      |=> bitcnt_ff == $past(bitcnt_ff))
      else $error("counter moved without clock edge");

   // [RL2] Sample edge counts
   a_cnt_steps: assert property ( // [RL2]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && sample_edge && !(mode4 && nss_fall))
      |=> bitcnt_ff == 3'($past(bitcnt_ff) + 3'h1))
      else $error("counter did not step on sample edge");

   // [RL1] Master select idle
   a_master_idle: assert property ( // [RL1]
      @(posedge clk) disable iff (!arst_n)
      ctrl.master_select_bit |-> !slave_active)
      else $error("slave active in master select");

   // [RL9] Upper mode bit idle
   a_mode_hi_idle: assert property ( // [RL9]
      @(posedge clk) disable iff (!arst_n)
      ctrl.select_mode_hi |-> !slave_active)
      else $error("slave active with upper mode bit set");

   // [RL10] Select high idle
   a_nss_high_idle: assert property ( // [RL10]
      @(posedge clk) disable iff (!arst_n)
      (mode4 && nss_lvl) |-> (!slave_active && miso_oe_n))
      else $error("port active with select high");

   // [RL13] Three wire active
   a_three_wire_act: assert property ( // [RL13]
      @(posedge clk) disable iff (!arst_n)
      (slave_en && mode3) |-> slave_active)
      else $error("three wire port not active");

   // [RL17] Interrupt from flag
   a_irq_gate: assert property ( // [RL17]
      @(posedge clk) disable iff (!arst_n)
      (flags_ff.xfer_done_flag && ctrl.irq_enable) |-> irq)
      else $error("interrupt missing");

   // [RL17] Done flag sticky
   a_done_sticky: assert property ( // [RL17]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && flags_ff.xfer_done_flag && !clr_done) |=> flags_ff.xfer_done_flag)
      else $error("done flag dropped without clear");

   // [RL6] Write fills buffer
   a_write_fills_buf: assert property ( // [RL6]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && wr_ok) |=> (txfull_ff && txbuf_ff == $past(wr_data)))
      else $error("write not held in transmit buffer");

   // [RL4] Read gives buffer
   a_read_returns: assert property ( // [RL4]
      @(posedge clk) disable iff (!arst_n)
      (clk_en && rd_strobe) |=> serial_data_reg == $past(rxbuf_ff))
      else $error("read did not return receive buffer");

endmodule // spsl_port

//--- spsl_master_model.sv
// Purpose: SPI master model driving the serial side of the port
// Assumes: Any clock polarity and phase, MSB first, 125 ns serial clock
// Notes: Clock idles at the polarity given by set_mode; mosi shows inverse data once released
`timescale 1ns/10ps
module spsl_master_model (
   output logic sck,
   output logic mosi,
   output logic nss_n,
   input wire logic miso,
   output logic [7:0] got,
   output logic got_v
);
   localparam real H = 62.5;
   logic cpol, cpha;
   initial begin
      cpol = 1'b0;
      cpha = 1'b0;
      sck = 1'b0;
      mosi = 1'b0;
      nss_n = 1'b1;
      got = 8'h00;
      got_v = 1'b0;
   end
   task automatic set_mode(input logic pol, input logic pha);
      cpol = pol;
      cpha = pha;
      sck = pol;
   endtask
   task automatic xfer(input logic [7:0] tx, input int n, input logic sel);
      nss_n = ~sel;
      #H;
      for (int i = 7; i > 7 - n; i--) begin
         if (!cpha) mosi = tx[i];
         #H;
         sck = ~cpol;
         if (!cpha) got[i] = miso;
         else mosi = tx[i];
         #H;
         sck = cpol;
         if (cpha) got[i] = miso;
      end
      #H;
      mosi = ~mosi;
      nss_n = 1'b1;
      got_v = (n == 8);
      #10;
      got_v = 1'b0;
   endtask
endmodule // spsl_master_model

//--- spsl_port_tb.sv
// Purpose: Self-checking bench for the SPI slave port
// Assumes: Master model follows the polarity and phase set here
// Notes: Expected master-side bytes wait in a queue for the monitor
`timescale 1ns/10ps
module spsl_port_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   spsl_pkg::spsl_ctrl_s ctrl = 7'h49;
   logic [7:0] wr_data = 8'h00;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic [2:0] clr = 3'h0;
   spsl_pkg::spsl_flags_s flags;
   logic [7:0] rdat, got, b1, b2, rx1;
   logic irq, act, sck, mosi, nss_n, miso, miso_oe_n, miso_w, got_v;
   logic [8:0] expq[$];
   logic [8:0] note;
   int err_total = 0;
   int total_checks = 0;
   int seed = 32'h5a4bf2d2;
   always #5 clk = ~clk;
   assign miso_w = miso_oe_n ? ~clk : miso;
   spsl_port u_spsl_port (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .ctrl(ctrl),
      .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .clr_done(clr[2]),
      .clr_collision(clr[1]), .clr_overrun(clr[0]), .serial_data_reg(rdat), .flags(flags),
      .irq(irq), .slave_active(act), .sck(sck), .mosi(mosi), .nss_n(nss_n), .miso(miso),
      .miso_oe_n(miso_oe_n));
   spsl_master_model u_spsl_master_model (.sck(sck), .mosi(mosi), .nss_n(nss_n),
      .miso(miso_w), .got(got), .got_v(got_v));
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] d);
      @(negedge clk);
      wr_data = d;
      wr_strobe = 1'b1;
      @(negedge clk);
      wr_strobe = 1'b0;
   endtask
   task automatic rd(input logic [7:0] exp);
      @(negedge clk);
      rd_strobe = 1'b1;
      @(negedge clk);
      rd_strobe = 1'b0;
      @(negedge clk);
      check("rx data", rdat, exp);
   endtask
   task automatic clr_f(input logic [2:0] m);
      @(negedge clk);
      clr = m;
      @(negedge clk);
      clr = 3'h0;
   endtask
   task automatic frame(input logic [7:0] tx, input int n, input logic sel, input logic [8:0] q);
      if (n == 8)
         expq.push_back(q);
      u_spsl_master_model.xfer(tx, n, sel);
      repeat (10) @(negedge clk);
   endtask
   always @(posedge got_v) begin
      note = expq.pop_front();
      if (note[8])
         check("miso byte", got, note[7:0]);
   end
   initial begin
      #200000;
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      check("rst flags", 8'(flags), 8'h00);
      check("rst oe", 8'(miso_oe_n), 8'h01);
      check("rst act", 8'(act), 8'h00);
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      rx1 = 8'($random(seed));
      wr(b1);
      repeat (2) @(negedge clk);
      wr(b2);
      wr(8'h3c);
      check("collision", 8'(flags), 8'h02);
      check("irq", 8'(irq), 8'h01);
      clr_f(3'h2);
      check("irq clr", 8'(irq), 8'h00);
      frame(rx1, 8, 1'b1, {1'b1, b1});
      check("done", 8'(flags), 8'h04);
      frame(~rx1, 8, 1'b1, {1'b1, b2});
      check("overrun", 8'(flags), 8'h05);
      rd(rx1);
      clr_f(3'h7);
      $display("test buffering done");
      rx1 = 8'($random(seed));
      frame(8'hff, 3, 1'b1, 9'h000);
      frame(rx1, 8, 1'b1, 9'h000);
      rd(rx1);
      clr_f(3'h4);
      u_spsl_master_model.set_mode(1'b1, 1'b1);
      @(negedge clk);
      ctrl.clk_pol = 1'b1;
      ctrl.clk_pha = 1'b1;
      b1 = 8'($random(seed));
      rx1 = 8'($random(seed));
      wr(b1);
      frame(rx1, 8, 1'b1, {1'b1, b1});
      check("pol pha done", 8'(flags), 8'h04);
      rd(rx1);
      clr_f(3'h4);
      u_spsl_master_model.set_mode(1'b0, 1'b0);
      @(negedge clk);
      ctrl.clk_pol = 1'b0;
      ctrl.clk_pha = 1'b0;
      frame(rx1, 8, 1'b0, 9'h000);
      check("nss high", 8'(flags), 8'h00);
      @(negedge clk);
      ctrl.master_select_bit = 1'b1;
      frame(rx1, 8, 1'b1, 9'h000);
      check("master sel", 8'(flags), 8'h00);
      @(negedge clk);
      ctrl.master_select_bit = 1'b0;
      ctrl.select_mode_hi = 1'b1;
      frame(rx1, 8, 1'b1, 9'h000);
      check("mode 1x", 8'(flags), 8'h00);
      $display("test four wire done");
      @(negedge clk);
      ctrl.select_mode_hi = 1'b0;
      ctrl.select_mode_lo = 1'b0;
      frame(8'h0f, 3, 1'b0, 9'h000);
      @(negedge clk);
      ctrl.port_enable_bit = 1'b0;
      @(negedge clk);
      ctrl.port_enable_bit = 1'b1;
      @(negedge clk);
      check("3w active", 8'(act), 8'h01);
      for (int k = 0; k < 3; k++) begin
         rx1 = 8'($random(seed));
         b1 = 8'($random(seed));
         wr(b1);
         frame(rx1, 8, 1'b0, {1'b1, b1});
         check("3w done", 8'(flags), 8'h04);
         rd(rx1);
         clr_f(3'h4);
      end
      $display("test three wire done");
      end_of_test();
   end
endmodule // spsl_port_tb
